// ### verilog/capture_compare_array_unit.sv
`timescale 1ns/100ps
`include "capture_compare_array_unit_cfg.svh"
// Behaviour
// (RULE1) Sixteen channels; one-cycle resolution, eight cycles when staggered.
// (RULE2) Two independent 16-bit timers, each with its own reload register.
// (RULE3) Timer clock is a prescaled system clock or neighbour overflow.
// (RULE4) Timers can also count pulses on external count inputs.
// (RULE5) Each channel picks either timer and capture or compare use.
// (RULE6) Each channel owns one pin: capture input or compare output.
// (RULE7) Capture edge copies the allocated timer into the channel.
// (RULE8) Every capture raises that channel's interrupt request.
// (RULE9) Capture edge is rising, falling or both, per channel.
// (RULE10) Compare channels match continuously; the mode sets the action.
// (RULE11) Mode 0 interrupts on every match and leaves the pin alone.
// (RULE12) Mode 1 toggles the pin on every match.
// (RULE13) Mode 2 interrupts on at most one match per timer period.
// (RULE14) Mode 3 sets pin on match, clears on overflow, once per period.
// (RULE15) Double mode: two registers share one pin; either match toggles.
// (RULE16) Single event option stops compare events after the first one.
// (RULE17) On overflow a timer reloads from its reload register.
// (RULE18) Match means timer equals register, checked once per increment.
module capture_compare_array_unit
    import cc_array_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Count sources
    input wire logic neigh_ovf,
    input wire logic [`CC_NEXT-1:0] ext_cnt_in,
    // Channel pins
    input wire logic [`CC_NCH-1:0] pin_in,
    output logic [`CC_NCH-1:0] pin_out,
    output logic [`CC_NCH-1:0] pin_oe,
    // Interrupt requests
    output logic [`CC_NCH-1:0] irq_req
);
    ////////////////////////////////////////////////////////////////////////
    logic [`CC_MREG_W-1:0] mode_reg [`CC_NCH];
    logic [`CC_TW-1:0] cc_reg [`CC_NCH];
    logic [`CC_TCTRL_W-1:0] tctrl_reg;
    logic [`CC_NCH-1:0] done_reg, fired_reg;
    logic [`CC_NCH-1:0] pin_next, oe_next;
    logic [`CC_NCH-1:0] ev, cap, wrap_ch;
    logic [`CC_NCH-1:0] mode_wr, val_wr;
    logic [`CC_NCH+`CC_NEXT-1:0] s_lvl, s_rise, s_fall;
    logic [`CC_TW-1:0] tval [2];
    logic [1:0] tstep, twrap;
    logic [`CC_TW-1:0] rld0, rld1;
    logic [31:0] rd_next;
    logic [3:0] idx;
    logic setup_ok, acc_wr, hit;

    timer_if tb0 ();
    timer_if tb1 ();

    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_cmp(input logic [`CC_MREG_W-1:0] m);
        chan_mode_t md;
        md = chan_mode_t'(m[`CC_MODE_MSB:0]);
        return md == M_CMP0 || md == M_CMP1 || md == M_CMP2 ||
            md == M_CMP3;
    endfunction

    function automatic chan_mode_t mode_of(
        input logic [`CC_MREG_W-1:0] m);
        return chan_mode_t'(m[`CC_MODE_MSB:0]);
    endfunction

    function automatic logic in_region(input logic [`CC_AW-1:0] a,
        input logic [`CC_AW-1:0] base);
        return (a & `CC_REGION_MASK) == base;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pins and external count inputs come from outside the clock domain.
    pin_sync #(
        .W(`CC_NCH + `CC_NEXT)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({ext_cnt_in, pin_in}),
        .lvl(s_lvl),
        .rise(s_rise),
        .fall(s_fall)
    );

    cc_timer u_tmr0 (
        .pclk(pclk),
        .presetn(presetn),
        .sel(tctrl_reg[`CC_SEL_W-1:0]),
        .run(tctrl_reg[`CC_TCTRL_RUN]),
        .stag(tctrl_reg[`CC_STAG_BIT]),
        .neigh_ovf(neigh_ovf),
        .ext_rise(s_rise[`CC_NCH]),
        .wr_cnt(acc_wr && paddr == `CC_OFS_TMR0),
        .wr_rld(acc_wr && paddr == `CC_OFS_RLD0),
        .wdata(pwdata[`CC_TW-1:0]),
        .rld_reg(rld0),
        .tb(tb0)
    );

    cc_timer u_tmr1 (
        .pclk(pclk),
        .presetn(presetn),
        .sel(tctrl_reg[`CC_TCTRL_STRIDE +: `CC_SEL_W]),
        .run(tctrl_reg[`CC_TCTRL_STRIDE + `CC_TCTRL_RUN]),
        .stag(tctrl_reg[`CC_STAG_BIT]),
        .neigh_ovf(neigh_ovf),
        .ext_rise(s_rise[`CC_NCH + 1]),
        .wr_cnt(acc_wr && paddr == `CC_OFS_TMR1),
        .wr_rld(acc_wr && paddr == `CC_OFS_RLD1),
        .wdata(pwdata[`CC_TW-1:0]),
        .rld_reg(rld1),
        .tb(tb1)
    );

    assign tval[0] = tb0.value;
    assign tval[1] = tb1.value;
    assign tstep = {tb1.step, tb0.step};
    assign twrap = {tb1.wrap, tb0.wrap};

    ////////////////////////////////////////////////////////////////////////
    // APB decode. One wait state lets every answer come from a flip-flop.
    assign idx = paddr[`CC_IDX_MSB:`CC_IDX_LSB];
    assign setup_ok = psel & penable & ~pready;
    assign acc_wr = psel & penable & pready & pwrite & ~pslverr;

    always_comb begin
        hit = 1'b1;
        rd_next = '0;
        if (in_region(paddr, `CC_MODE_BASE)) begin
            rd_next[`CC_MREG_W-1:0] = mode_reg[idx];
        end else if (in_region(paddr, `CC_VAL_BASE)) begin
            rd_next[`CC_TW-1:0] = cc_reg[idx];
        end else begin
            case (paddr)
                `CC_OFS_TMR0: rd_next[`CC_TW-1:0] = tval[0];
                `CC_OFS_RLD0: rd_next[`CC_TW-1:0] = rld0;
                `CC_OFS_TMR1: rd_next[`CC_TW-1:0] = tval[1];
                `CC_OFS_RLD1: rd_next[`CC_TW-1:0] = rld1;
                `CC_OFS_TCTRL: rd_next[`CC_TCTRL_W-1:0] = tctrl_reg;
                `CC_OFS_PINS: rd_next = {s_lvl[`CC_NCH-1:0], pin_out};
                default: hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup_ok;
            pslverr <= setup_ok & ~hit;
            if (setup_ok) begin
                prdata <= pwrite ? '0 : rd_next;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < `CC_NCH; i++) begin
            mode_wr[i] = acc_wr && in_region(paddr, `CC_MODE_BASE) &&
                idx == 4'(i);
            val_wr[i] = acc_wr && in_region(paddr, `CC_VAL_BASE) &&
                idx == 4'(i);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tctrl_reg <= `CC_TCTRL_RST;
        end else if (acc_wr && paddr == `CC_OFS_TCTRL) begin
            tctrl_reg <= pwdata[`CC_TCTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `CC_NCH; i++) begin
                mode_reg[i] <= `CC_MREG_RST;
            end
        end else begin
            for (int i = 0; i < `CC_NCH; i++) begin
                if (mode_wr[i]) begin
                    mode_reg[i] <= pwdata[`CC_MREG_W-1:0]; // see (RULE5)
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel events.
    always_comb begin
        for (int i = 0; i < `CC_NCH; i++) begin
            logic ts;
            logic once;
            logic match;
            chan_mode_t md;
            ts = mode_reg[i][`CC_TSEL_BIT]; // see (RULE5)
            md = mode_of(mode_reg[i]);
            wrap_ch[i] = twrap[ts];
            match = is_cmp(mode_reg[i]) && tstep[ts] &&
                tval[ts] == cc_reg[i]; // see (RULE10) (RULE18)
            once = md == M_CMP2 || md == M_CMP3; // see (RULE13) (RULE14)
            ev[i] = match && !(once && fired_reg[i]) &&
                !(mode_reg[i][`CC_SINGLE_BIT] && done_reg[i]); // see (RULE16)
            case (md)
                M_CAP_RISE: cap[i] = s_rise[i]; // see (RULE9)
                M_CAP_FALL: cap[i] = s_fall[i]; // see (RULE9)
                M_CAP_BOTH: cap[i] = s_rise[i] | s_fall[i]; // see (RULE9)
                default: cap[i] = 1'b0;
            endcase
        end
    end

    // A capture wins over a software write to the same register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `CC_NCH; i++) begin
                cc_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `CC_NCH; i++) begin
                if (cap[i]) begin
                    cc_reg[i] <= tval[mode_reg[i][`CC_TSEL_BIT]]; // see (RULE7)
                end else if (val_wr[i]) begin
                    cc_reg[i] <= pwdata[`CC_TW-1:0];
                end
            end
        end
    end

    // The period flag is set by an event and cleared by the allocated
    // timer's overflow; an event in the overflow cycle keeps it set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fired_reg <= '0;
            done_reg <= '0;
        end else begin
            fired_reg <= ev | (fired_reg & ~wrap_ch); // see (RULE13)
            done_reg <= ev | (done_reg & ~mode_wr); // see (RULE16)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive.
    always_comb begin
        pin_next = pin_out;
        oe_next = '0;
        for (int i = 0; i < `CC_NCH; i++) begin
            if (mode_of(mode_reg[i]) == M_CMP3 && wrap_ch[i]) begin
                pin_next[i] = 1'b0; // see (RULE14)
            end
        end
        for (int i = 0; i < `CC_NCH; i++) begin
            if (i >= `CC_HALF && mode_reg[i][`CC_DOUBLE_BIT]) begin
                if (ev[i]) begin
                    pin_next[i - `CC_HALF] =
                        ~pin_next[i - `CC_HALF]; // see (RULE15)
                end
                if (is_cmp(mode_reg[i])) begin
                    oe_next[i - `CC_HALF] = 1'b1; // see (RULE15)
                end
            end else begin
                if (ev[i] && mode_of(mode_reg[i]) == M_CMP1) begin
                    pin_next[i] = ~pin_next[i]; // see (RULE12)
                end else if (ev[i] && mode_of(mode_reg[i]) == M_CMP3) begin
                    pin_next[i] = 1'b1; // see (RULE14)
                end
                if (is_cmp(mode_reg[i])) begin
                    oe_next[i] = 1'b1; // see (RULE6)
                end
            end
        end
    end

    // Modes 0 and 2 only request interrupts, except on an upper channel in double mode, where a match toggles the partner's pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= pin_next; // see (RULE6) (RULE11)
            pin_oe <= oe_next; // see (RULE6)
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= '0;
        end else begin
            irq_req <= cap | ev; // see (RULE8) (RULE11) (RULE13)
        end
    end
endmodule

// ### common/capture_compare_array_unit_cfg.svh
`ifndef CC_ARRAY_CFG_SVH
`define CC_ARRAY_CFG_SVH

// Register byte addresses.
`define CC_OFS_TMR0 8'h00
`define CC_OFS_RLD0 8'h04
`define CC_OFS_TMR1 8'h08
`define CC_OFS_RLD1 8'h0C
`define CC_OFS_TCTRL 8'h10
`define CC_OFS_PINS 8'h14
`define CC_MODE_BASE 8'h40
`define CC_VAL_BASE 8'h80
`define CC_REGION_MASK 8'hC0
`define CC_IDX_MSB 5
`define CC_IDX_LSB 2

// Sizes.
`define CC_AW 8
`define CC_TW 16
`define CC_NCH 16
`define CC_HALF 8
`define CC_NEXT 2
`define CC_PRE_W 5
`define CC_STAG_CYC 8
`define CC_STAG_W 3
`define CC_TMAX 16'hFFFF

// Channel mode register fields.
`define CC_MREG_W 6
`define CC_MODE_MSB 2
`define CC_TSEL_BIT 3
`define CC_SINGLE_BIT 4
`define CC_DOUBLE_BIT 5
`define CC_MREG_RST 6'h00

// Timer control register fields.
`define CC_SEL_W 3
`define CC_TCTRL_STRIDE 4
`define CC_TCTRL_RUN 3
`define CC_STAG_BIT 8
`define CC_TCTRL_W 9
`define CC_TCTRL_RST 9'h000
`define CC_SEL_NEIGH 3'h6
`define CC_SEL_EXT 3'h7

`endif

// ### common/capture_compare_array_unit_pkg.sv
package cc_array_pkg;

    typedef enum logic [2:0] {
        M_OFF, M_CAP_RISE, M_CAP_FALL, M_CAP_BOTH,
        M_CMP0, M_CMP1, M_CMP2, M_CMP3
    } chan_mode_t;

endpackage

// ### common/timer_if.sv
`timescale 1ns/100ps
interface timer_if;
    logic [15:0] value;
    logic step;
    logic wrap;
    modport src (output value, output step, output wrap);
    modport dst (input value, input step, input wrap);
endinterface

// ### verilog/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw pins
    input wire logic [W-1:0] din,
    // Filtered level and edges
    output logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg;
    logic [W-1:0] agree;

    if (W < 1) begin : g_chk
        $error("pin_sync needs at least one bit.");
    end

    assign agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts only once the two later stages agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl <= '0;
            rise <= '0;
            fall <= '0;
        end else begin
            rise <= agree & s3_reg & ~lvl;
            fall <= agree & ~s3_reg & lvl;
            lvl <= (agree & s3_reg) | (~agree & lvl);
        end
    end
endmodule

// ### verilog/cc_timer.sv
`timescale 1ns/100ps
`include "capture_compare_array_unit_cfg.svh"
module cc_timer #(
    parameter int PRE_W = `CC_PRE_W
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Count source control
    input wire logic [`CC_SEL_W-1:0] sel,
    input wire logic run,
    input wire logic stag,
    input wire logic neigh_ovf,
    input wire logic ext_rise,
    // Software access
    input wire logic wr_cnt,
    input wire logic wr_rld,
    input wire logic [`CC_TW-1:0] wdata,
    output logic [`CC_TW-1:0] rld_reg,
    // Time base
    timer_if.src tb
);
    logic [PRE_W-1:0] pre_reg;
    logic [PRE_W-1:0] mask;
    logic [`CC_STAG_W-1:0] phase_reg;
    logic [`CC_TW-1:0] cnt_reg;
    logic step_reg, wrap_reg, src, tick;

    if (PRE_W < `CC_PRE_W) begin : g_chk
        $error("Prescaler too narrow for the largest division.");
    end

    assign mask = PRE_W'((1 << sel) - 1);
    assign tb.value = cnt_reg;
    assign tb.step = step_reg;
    assign tb.wrap = wrap_reg;

    always_comb begin
        case (sel)
            `CC_SEL_NEIGH: src = neigh_ovf; // see (RULE3)
            `CC_SEL_EXT: src = ext_rise; // see (RULE4)
            default: src = (pre_reg & mask) == '0; // see (RULE3)
        endcase
    end

    // Staggered operation only lets one cycle in eight count, so sources
    // pulsing on other phases are missed.
    assign tick = run & src & (~stag | (phase_reg == '0)); // see (RULE1)

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '0;
            phase_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
            phase_reg <= phase_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rld_reg <= '0;
        end else if (wr_rld) begin
            rld_reg <= wdata;
        end
    end

    // Software writes win over a count in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            step_reg <= 1'b0;
            wrap_reg <= 1'b0;
        end else begin
            step_reg <= tick & ~wr_cnt;
            wrap_reg <= tick & ~wr_cnt & (cnt_reg == `CC_TMAX);
            if (wr_cnt) begin
                cnt_reg <= wdata;
            end else if (tick) begin
                if (cnt_reg == `CC_TMAX) begin
                    cnt_reg <= rld_reg; // see (RULE17)
                end else begin
                    cnt_reg <= cnt_reg + 1'b1; // see (RULE2)
                end
            end
        end
    end
endmodule

// ### test/cc_pin_model.sv
`timescale 1ns/100ps
module cc_pin_model (
    // Clock
    input wire logic pclk,
    // Lines toward the unit
    output logic neigh_ovf,
    output logic [1:0] ext_cnt_in,
    output logic [15:0] pin_in
);
    initial begin
        neigh_ovf = 1'b0;
        ext_cnt_in = 2'b00;
        pin_in = 16'h0000;
    end

    ////////////////////////////////////////
    // One-cycle pulse, spaced so each step settles before the next.
    task automatic tick();
        @(posedge pclk);
        neigh_ovf <= 1'b1;
        @(posedge pclk);
        neigh_ovf <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask

    // Levels are held four cycles since the pins pass a synchroniser.
    task automatic ext_pulse(input int i);
        @(posedge pclk);
        ext_cnt_in[i] <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_cnt_in[i] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic set_pins(input logic [15:0] v);
        @(posedge pclk);
        pin_in <= v;
        repeat (12) @(posedge pclk);
    endtask
endmodule

// ### test/cc_asserts.sv
`timescale 1ns/100ps
`include "capture_compare_array_unit_cfg.svh"
module cc_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and events
    input wire logic neigh_ovf,
    input wire logic [`CC_NEXT-1:0] ext_cnt_in,
    input wire logic [`CC_NCH-1:0] pin_in,
    input wire logic [`CC_NCH-1:0] pin_out,
    input wire logic [`CC_NCH-1:0] pin_oe,
    input wire logic [`CC_NCH-1:0] irq_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rdy_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("late pready");
    property p_rdy_one;
        pready |=> !pready;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("long pready");
    property p_rdy_req;
        pready |-> psel && penable;
    endproperty
    a_rdy_req: assert property (p_rdy_req) else $error("stray pready");
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("bad pslverr");
    property p_wr_zero;
        pready && pwrite |-> prdata == 32'h0;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("prdata on write");
    property p_rst_out;
        $rose(presetn) |-> pin_oe == 16'h0 && irq_req == 16'h0;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("output after reset");
    property p_irq_pulse;
        (irq_req & $past(irq_req)) == 16'h0;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq held");
    // A pin only rises with an event of its own channel or its partner.
    property p_pin_rise;
        (pin_out & ~$past(pin_out) & ~(irq_req | (irq_req >> 8))) == 16'h0;
    endproperty
    a_pin_rise: assert property (p_pin_rise) else $error("pin rise");
    property p_oe_cause;
        $changed(pin_oe) |-> $past(pready && pwrite)
            || $past(pready && pwrite, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("oe moved");
endmodule

bind capture_compare_array_unit cc_asserts i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .neigh_ovf(neigh_ovf),
    .ext_cnt_in(ext_cnt_in), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq_req(irq_req)
);

// ### test/sixteen_channel_capture_compare_tb_top.sv
`timescale 1ns/100ps
`include "capture_compare_array_unit_cfg.svh"
module sixteen_channel_capture_compare_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, neigh_ovf, er;
    logic [1:0] ext_cnt_in;
    logic [15:0] pin_in, pin_out, pin_oe, irq_req;
    int irq_cnt [16];
    int error_cnt = 0;
    int tests_run = 0;

    always #2.5 pclk = ~pclk;

    capture_compare_array_unit i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .neigh_ovf(neigh_ovf),
        .ext_cnt_in(ext_cnt_in), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .irq_req(irq_req)
    );
    cc_pin_model i_pins (
        .pclk(pclk), .neigh_ovf(neigh_ovf), .ext_cnt_in(ext_cnt_in),
        .pin_in(pin_in)
    );

    always @(posedge pclk) begin
        for (int i = 0; i < 16; i++) begin
            if (irq_req[i] === 1'b1) begin
                irq_cnt[i]++;
            end
        end
    end

    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Request held until pready is sampled high, then released.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
        @(posedge pclk);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    ////////////////////////////////////////
    task automatic t_regs();
        rdc("tctrl", `CC_OFS_TCTRL, 32'h0);
        rdc("mode15", `CC_MODE_BASE + 8'h3C, 32'h0);
        apb(1'b1, `CC_OFS_RLD0, 32'hABCD1234);
        rdc("rld0", `CC_OFS_RLD0, 32'h1234);
        apb(1'b1, `CC_OFS_PINS, 32'hFFFFFFFF);
        rdc("pins_ro", `CC_OFS_PINS, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er});
    endtask

    task automatic t_capture();
        apb(1'b1, `CC_OFS_TMR0, 32'h1234);
        apb(1'b1, `CC_OFS_TMR1, 32'h5678);
        apb(1'b1, `CC_MODE_BASE + 8'h04, 32'h01);
        apb(1'b1, `CC_MODE_BASE + 8'h08, 32'h0A);
        apb(1'b1, `CC_MODE_BASE + 8'h0C, 32'h03);
        chk("cap_oe", 32'h0, {16'h0, pin_oe});
        i_pins.set_pins(16'h000E);
        i_pins.set_pins(16'h0000);
        for (int i = 1; i < 4; i++) begin
            chk($sformatf("cap_irq%0d", i), i == 3 ? 2 : 1, irq_cnt[i]);
        end
        rdc("cap1", `CC_VAL_BASE + 8'h04, 32'h1234);
        rdc("cap2", `CC_VAL_BASE + 8'h08, 32'h5678);
        rdc("cap3", `CC_VAL_BASE + 8'h0C, 32'h1234);
    endtask

    task automatic t_ext();
        apb(1'b1, `CC_OFS_TCTRL, 32'h0F0);
        repeat (3) i_pins.ext_pulse(1);
        rdc("ext_cnt", `CC_OFS_TMR1, 32'h567B);
    endtask

    task automatic t_compare();
        int ch[7] = '{0, 4, 5, 6, 7, 8, 9};
        logic [5:0] md[7] = '{6'h05, 6'h04, 6'h05, 6'h06, 6'h07, 6'h25, 6'h15};
        int ex[10] = '{3, 0, 0, 0, 3, 3, 2, 2, 1, 1};
        apb(1'b1, `CC_OFS_RLD0, 32'hFFFC);
        apb(1'b1, `CC_OFS_TMR0, 32'hFFFC);
        for (int k = 0; k < 7; k++) begin
            apb(1'b1, `CC_VAL_BASE + 8'(4 * ch[k]),
                ch[k] == 8 ? 32'hFFFE : 32'hFFFD);
            apb(1'b1, `CC_MODE_BASE + 8'(4 * ch[k]), {26'h0, md[k]});
        end
        chk("cmp_oe", 32'hF1, {24'h0, pin_oe[7:0]});
        apb(1'b1, `CC_OFS_TCTRL, 32'h0FE);
        irq_cnt = '{default: 0};
        i_pins.tick();
        // Rewinding the count repeats a match inside one period.
        apb(1'b1, `CC_OFS_TMR0, 32'hFFFC);
        i_pins.tick();
        chk("m2_once", 32'h1, irq_cnt[6]);
        repeat (3) i_pins.tick();
        chk("m3_clr", 32'h0, {31'h0, pin_out[7]});
        rdc("reload", `CC_OFS_TMR0, 32'hFFFC);
        i_pins.tick();
        for (int i = 0; i < 10; i++) begin
            chk($sformatf("irq%0d", i), ex[i], irq_cnt[i]);
        end
        chk("pins", 32'h2A0, {16'h0, pin_out & 16'h02B1});
    endtask

    // The timer may count on 48 edges between the two control writes, so
    // divide by four gives twelve steps and staggered operation six.
    task automatic t_rate();
        apb(1'b1, `CC_OFS_TMR0, 32'h0);
        apb(1'b1, `CC_OFS_TCTRL, 32'h00A);
        repeat (44) @(posedge pclk);
        apb(1'b1, `CC_OFS_TCTRL, 32'h0);
        rdc("div4", `CC_OFS_TMR0, 32'hC);
        apb(1'b1, `CC_OFS_TMR0, 32'h0);
        apb(1'b1, `CC_OFS_TCTRL, 32'h108);
        repeat (44) @(posedge pclk);
        apb(1'b1, `CC_OFS_TCTRL, 32'h0);
        rdc("stagger", `CC_OFS_TMR0, 32'h6);
    endtask

    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_capture();
        t_ext();
        t_compare();
        t_rate();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end
endmodule
